// ---- design/wdt_pkg.sv ----
// package: register map, field layout and timing constants of the watchdog
package wdt_pkg;
	// byte offsets on the axi4-lite bus
	localparam logic [7:0] ADDR_CTRL = 8'h00;   // watchdog_control
	localparam logic [7:0] ADDR_CFG = 8'h04;    // watchdog_config_word
	localparam logic [7:0] ADDR_STAT = 8'h08;   // sticky event status
	localparam logic [7:0] ADDR_MASK = 8'h0c;   // interrupt mask
	localparam logic [7:0] ADDR_CMD = 8'h10;    // instruction strobes
	localparam logic [7:0] ADDR_OSC = 8'h14;    // osc_control_reg copy
	localparam logic [7:0] ADDR_CNT = 8'h18;    // live postscaler count
	// field positions
	localparam int CTRL_SWEN_BIT = 0;
	localparam int CFG_EN_LSB = 0;
	localparam int CFG_PS_LSB = 2;
	localparam int CMD_CLR_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	localparam int CMD_WAKE_BIT = 2;
	localparam int OSC_FSEL_LSB = 4;
	localparam int STAT_TO_BIT = 0;
	localparam int STAT_WAKE_BIT = 1;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h3f;
	localparam logic [7:0] OSC_RST = 8'h30;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// enable configuration encodings
	typedef enum logic [1:0] {
		WDT_OFF = 2'h0,
		WDT_AWAKE = 2'h1,
		WDT_SOFT = 2'h2,
		WDT_ON = 2'h3
	} wdt_en_e;
	// timing: base period and system clock period
	localparam int BASE_PERIOD_US = 4000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BASE_CYCLES = BASE_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int PS_BITS = 16;
endpackage

// ---- design/wdt_top.sv ----
// watchdog timer with postscaler, axi4-lite register slave and interrupt
//
// Contract
// - watchdog runs from low-frequency oscillator, enabled together (here the counts run on clk_sys_i; lfosc_en_o only follows the enable)
// - base count period nominally 4 ms
// - 16-bit postscaler, tap chosen by multiplexer
// - timeout spans 4 ms to 131.072 s
// - sleep or clear instruction clears both counts
// - oscillator frequency select change clears counts
// - clock failure clears counts
// - software enable at control bit 0, resets 0
// - software bit only matters under software mode
// - postscale ratio is two to field value
// - 11 always on, 00 off, 10 software
// - 01 runs while awake, stops in sleep
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module wdt_top #(
	parameter int BASE_CNT = wdt_pkg::BASE_CYCLES,
	parameter int PS_W = wdt_pkg::PS_BITS
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic clk_fail_i,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic lfosc_en_o,
	output logic wdt_reset_o,
	output logic wdt_wake_o,
	output logic sleeping_o,
	output logic irq_o
);
	// elaboration check: the tap decode serves a 16-bit postscaler only
	if (BASE_CNT < 2 || PS_W != wdt_pkg::PS_BITS)
	begin : g_bad_param
		$error("wdt_top: unsupported parameter values");
	end

	// register state
	logic [7:0] ctrl_r;          // software enable lives here
	logic [7:0] cfg_r;           // enable mode and postscale select
	logic [7:0] osc_r;           // oscillator control copy
	logic [1:0] stat_r;          // sticky events
	logic [1:0] mask_r;          // interrupt mask
	logic sleep_r;               // device asleep
	logic [31:0] base_r;         // base period divider
	logic [PS_W-1:0] ps_r;       // postscaler count
	logic clr_instr;             // clear instruction strobe
	logic sleep_instr;           // sleep instruction strobe
	logic wake_cmd;              // external wake strobe
	logic fsel_chg;              // frequency select changed
	logic wdt_en;                // watchdog running
	logic base_tick;             // base period done
	logic expire;                // selected tap expired
	logic clr_all;               // any clearing event
	// axi write side
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic [1:0] ev_set;

	wdt_pkg::wdt_en_e en_mode;
	logic [3:0] ps_sel;
	assign en_mode = wdt_pkg::wdt_en_e'(cfg_r[wdt_pkg::CFG_EN_LSB +: 2]);
	assign ps_sel = cfg_r[wdt_pkg::CFG_PS_LSB +: 4];

	// enable decode: software bit counts only in software mode
	always_comb
	begin
		case (en_mode)
			wdt_pkg::WDT_OFF: wdt_en = 1'b0;
			wdt_pkg::WDT_AWAKE: wdt_en = !sleep_r;
			wdt_pkg::WDT_SOFT:
				wdt_en = ctrl_r[wdt_pkg::CTRL_SWEN_BIT];
			wdt_pkg::WDT_ON: wdt_en = 1'b1;
			default: wdt_en = 1'b0;
		endcase
	end

	// a write lands when both address and data are held
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign clr_instr = wr_go && awaddr_r == wdt_pkg::ADDR_CMD
		&& wstrb_r[0] && wdata_r[wdt_pkg::CMD_CLR_BIT];
	assign sleep_instr = wr_go && awaddr_r == wdt_pkg::ADDR_CMD
		&& wstrb_r[0] && wdata_r[wdt_pkg::CMD_SLEEP_BIT];
	assign wake_cmd = wr_go && awaddr_r == wdt_pkg::ADDR_CMD
		&& wstrb_r[0] && wdata_r[wdt_pkg::CMD_WAKE_BIT];
	// only a real change of the select field clears the counts
	assign fsel_chg = wr_go && awaddr_r == wdt_pkg::ADDR_OSC && wstrb_r[0]
		&& wdata_r[wdt_pkg::OSC_FSEL_LSB +: 3]
		!= osc_r[wdt_pkg::OSC_FSEL_LSB +: 3];
	assign clr_all = clr_instr || sleep_instr || fsel_chg
		|| clk_fail_i || !wdt_en;

	// base tick every BASE_CNT cycles of the system clock (4 ms by default)
	assign base_tick = base_r == 32'(BASE_CNT - 1);
	// tap mux: ratio 2**sel; expire when the selected bit span is full
	always_comb
	begin
		expire = 1'b0;
		if (base_tick)
			expire = (ps_r & ((PS_W'(1) << ps_sel) - PS_W'(1)))
				== ((PS_W'(1) << ps_sel) - PS_W'(1));
	end

	// base divider
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || clr_all || base_tick)
			base_r <= '0;
		else
			base_r <= base_r + 32'd1;
	end

	// postscaler: restarts after each timeout so timeouts keep
	// coming at the chosen period (4 ms .. 131.072 s)
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i || clr_all || expire)
			ps_r <= '0;
		else if (base_tick)
			ps_r <= ps_r + PS_W'(1);
	end

	// timeout outputs: reset while awake, wake while asleep
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			wdt_reset_o <= 1'b0;
			wdt_wake_o <= 1'b0;
		end
		else
		begin
			wdt_reset_o <= expire && !sleep_r;
			wdt_wake_o <= expire && sleep_r;
		end
	end

	// oscillator enable follows the watchdog enable
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			lfosc_en_o <= 1'b0;
		else
			lfosc_en_o <= wdt_en;
	end

	// sleep state: entered by the sleep strobe, left on any wake
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			sleep_r <= 1'b0;
		else if (wake_cmd || (expire && sleep_r))
			sleep_r <= 1'b0;
		else if (sleep_instr)
			sleep_r <= 1'b1;
	end
	assign sleeping_o = sleep_r;

	// control, config and oscillator registers
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			ctrl_r <= wdt_pkg::CTRL_RST;
			cfg_r <= wdt_pkg::CFG_RST;
			osc_r <= wdt_pkg::OSC_RST;
			mask_r <= '0;
		end
		else if (wr_go && wstrb_r[0])
		begin
			case (awaddr_r)
				wdt_pkg::ADDR_CTRL:
					ctrl_r <= {7'h00, wdata_r[wdt_pkg::CTRL_SWEN_BIT]};
				wdt_pkg::ADDR_CFG: cfg_r <= {2'h0, wdata_r[5:0]};
				wdt_pkg::ADDR_OSC: osc_r <= wdata_r[7:0];
				wdt_pkg::ADDR_MASK: mask_r <= wdata_r[1:0];
				default: ;
			endcase
		end
	end

	// sticky status: set wins over a write-one clear in the same cycle
	assign ev_set = {expire && sleep_r, expire && !sleep_r};
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			stat_r <= '0;
		else if (wr_go && wstrb_r[0] && awaddr_r == wdt_pkg::ADDR_STAT)
			stat_r <= (stat_r & ~wdata_r[1:0]) | ev_set;
		else
			stat_r <= stat_r | ev_set;
	end

	// level interrupt from unmasked status
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(stat_r & mask_r);
	end

	// write address and data accepted independently, one at a time
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= wdt_pkg::RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_r > wdt_pkg::ADDR_OSC
					|| awaddr_r[1:0] != 2'h0)
					? wdt_pkg::RESP_SLVERR : wdt_pkg::RESP_OKAY;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// ready only while the holding slot is free
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end

	// read channel: one read at a time, answer one cycle after address
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= wdt_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready
				&& s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= wdt_pkg::RESP_OKAY;
				case (s_axi_araddr[7:0])
					wdt_pkg::ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_r};
					wdt_pkg::ADDR_CFG: s_axi_rdata <= {24'h0, cfg_r};
					wdt_pkg::ADDR_STAT: s_axi_rdata <= {30'h0, stat_r};
					wdt_pkg::ADDR_MASK: s_axi_rdata <= {30'h0, mask_r};
					wdt_pkg::ADDR_CMD: s_axi_rdata <= {31'h0, sleep_r};
					wdt_pkg::ADDR_OSC: s_axi_rdata <= {24'h0, osc_r};
					wdt_pkg::ADDR_CNT: s_axi_rdata <= 32'(ps_r);
					default:
					begin
						s_axi_rdata <= '0;
						s_axi_rresp <= wdt_pkg::RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// assertions
	sequence s_tick_exp;
		base_tick && expire && !sleep_r;
	endsequence
	property p_reset_pulse;
		@(posedge clk_sys_i) disable iff (srst_i)
		s_tick_exp |=> wdt_reset_o;
	endproperty
	a_reset_pulse: assert property (p_reset_pulse)
		else $error("timeout while awake did not pulse reset");
	property p_wake_pulse;
		@(posedge clk_sys_i) disable iff (srst_i)
		(expire && sleep_r) |=> (wdt_wake_o && !sleep_r);
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("timeout in sleep did not wake");
	property p_off_holds;
		@(posedge clk_sys_i) disable iff (srst_i)
		(en_mode == wdt_pkg::WDT_OFF) |=> (ps_r == '0 && base_r == '0);
	endproperty
	a_off_holds: assert property (p_off_holds)
		else $error("counts moved while forced off");
	property p_clr;
		@(posedge clk_sys_i) disable iff (srst_i)
		(clr_instr || sleep_instr) |=> (ps_r == '0 && base_r == '0);
	endproperty
	a_clr: assert property (p_clr)
		else $error("instruction did not clear counts");
	property p_fail;
		@(posedge clk_sys_i) disable iff (srst_i)
		clk_fail_i |=> (ps_r == '0 && base_r == '0);
	endproperty
	a_fail: assert property (p_fail)
		else $error("clock failure did not clear counts");
	property p_fsel;
		@(posedge clk_sys_i) disable iff (srst_i)
		fsel_chg |=> (ps_r == '0 && base_r == '0);
	endproperty
	a_fsel: assert property (p_fsel)
		else $error("frequency select change did not clear counts");
	property p_osc;
		@(posedge clk_sys_i) disable iff (srst_i)
		wdt_en |=> lfosc_en_o;
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator not enabled with watchdog");
	property p_soft_ign;
		@(posedge clk_sys_i) disable iff (srst_i)
		(en_mode == wdt_pkg::WDT_ON || en_mode == wdt_pkg::WDT_OFF)
			|=> lfosc_en_o == ($past(en_mode) == wdt_pkg::WDT_ON);
	endproperty
	a_soft_ign: assert property (p_soft_ign)
		else $error("hardware mode did not override software bit");
	property p_awake;
		@(posedge clk_sys_i) disable iff (srst_i)
		(en_mode == wdt_pkg::WDT_AWAKE && sleep_r)
			|=> (ps_r == '0 && base_r == '0);
	endproperty
	a_awake: assert property (p_awake)
		else $error("awake-only mode ran in sleep");
	property p_base;
		@(posedge clk_sys_i) disable iff (srst_i)
		base_r <= 32'(BASE_CNT - 1);
	endproperty
	a_base: assert property (p_base)
		else $error("base divider ran past its period");
	property p_swen_rst;
		@(posedge clk_sys_i) $fell(srst_i) |-> ctrl_r == wdt_pkg::CTRL_RST;
	endproperty
	a_swen_rst: assert property (p_swen_rst)
		else $error("software enable not zero after reset");
endmodule

// ---- dv/test_wdt_top.sv ----
// self-checking testbench of the postscaled watchdog block
`timescale 1ns/1ns
module test_wdt_top;
	localparam int BASE = 4; // short base count keeps the run brief
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1; // held high for six cycles at start
	logic clk_fail_i = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic lfosc_en_o, wdt_reset_o, wdt_wake_o, sleeping_o, irq_o;
	int err_count = 0, cmp_count = 0;
	int rst_cnt = 0, wake_cnt = 0; // pulses seen on the event outputs
	int c;

	wdt_top #(.BASE_CNT(BASE), .PS_W(16)) u_wdt_top (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .clk_fail_i(clk_fail_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.lfosc_en_o(lfosc_en_o), .wdt_reset_o(wdt_reset_o),
		.wdt_wake_o(wdt_wake_o), .sleeping_o(sleeping_o), .irq_o(irq_o));

	// free-running 100 MHz clock
	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// count the one-cycle event pulses so tasks can watch them
	always @(posedge clk_sys_i)
	begin
		rst_cnt <= rst_cnt + int'(wdt_reset_o);
		wake_cnt <= wake_cnt + int'(wdt_wake_o);
	end

	// compare and report at once
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// single place where the run ends
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// axi4-lite write; address and data offered together, okay expected
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 0;
		@(posedge clk_sys_i);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge clk_sys_i);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				check({30'h0, bresp}, {30'h0, wdt_pkg::RESP_OKAY});
				bready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
			err_count++; // a hung slave counts as a mismatch
	endtask

	// axi4-lite read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk_sys_i);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !done; n++)
		begin
			@(posedge clk_sys_i);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				check(rdata, exp);
				check({30'h0, rresp}, {30'h0, er});
				rready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
			err_count++;
	endtask

	// cycles until the next reset (wk=0) or wake (wk=1) pulse, bounded
	task automatic gap(input bit wk, output int n);
		int n0;
		n0 = wk ? wake_cnt : rst_cnt;
		n = 0;
		while ((wk ? wake_cnt : rst_cnt) == n0 && n < 3000)
		begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask

	// no event pulse of either kind for the given span
	task automatic quiet(input int span);
		int r0, w0;
		r0 = rst_cnt;
		w0 = wake_cnt;
		repeat (span) @(posedge clk_sys_i);
		check(rst_cnt - r0 + wake_cnt - w0, 0);
	endtask

	// config word: postscale field above the two enable bits
	function automatic logic [31:0] cfg(input int ps, input logic [1:0] en);
		return {26'h0, ps[3:0], en};
	endfunction

	// reset values and an unmapped address
	task automatic t_reset();
		rd(wdt_pkg::ADDR_CTRL, 32'h0, wdt_pkg::RESP_OKAY);
		rd(wdt_pkg::ADDR_CFG, 32'h3f, wdt_pkg::RESP_OKAY);
		rd(wdt_pkg::ADDR_OSC, 32'h30, wdt_pkg::RESP_OKAY);
		rd(8'h1c, 32'h0, wdt_pkg::RESP_SLVERR);
		check(32'(lfosc_en_o), 32'h1);
		$display("reset test done");
	endtask

	// timeout period is base times two to the postscale field
	task automatic t_period();
		for (int ps = 0; ps < 5; ps++)
		begin
			wr(wdt_pkg::ADDR_CFG, cfg(ps, 2'h3));
			gap(0, c);
			gap(0, c);
			check(32'(c >= (BASE << ps) && c <= (BASE << ps) + 1),
				32'h1);
		end
		// a far tap: the multiplexer must reach beyond the low bits
		wr(wdt_pkg::ADDR_CFG, cfg(9, 2'h3));
		gap(0, c);
		gap(0, c);
		check(32'(c >= (BASE << 9) && c <= (BASE << 9) + 1),
			32'h1);
		$display("period test done");
	endtask

	// status flag, mask and level interrupt, then hardware off
	task automatic t_irq();
		wr(wdt_pkg::ADDR_MASK, 32'h1);
		wr(wdt_pkg::ADDR_STAT, 32'h3);
		wr(wdt_pkg::ADDR_CFG, cfg(3, 2'h3));
		gap(0, c);
		wr(wdt_pkg::ADDR_CFG, cfg(3, 2'h0)); // stop further events
		repeat (2) @(posedge clk_sys_i);
		check(32'(irq_o), 32'h1);
		wr(wdt_pkg::ADDR_MASK, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		check(32'(irq_o), 32'h0);
		wr(wdt_pkg::ADDR_MASK, 32'h1);
		rd(wdt_pkg::ADDR_STAT, 32'h1, wdt_pkg::RESP_OKAY);
		wr(wdt_pkg::ADDR_STAT, 32'h1);
		repeat (2) @(posedge clk_sys_i);
		check(32'(irq_o), 32'h0);
		rd(wdt_pkg::ADDR_STAT, 32'h0, wdt_pkg::RESP_OKAY);
		quiet(200);
		rd(wdt_pkg::ADDR_CNT, 32'h0, wdt_pkg::RESP_OKAY);
		$display("interrupt test done");
	endtask

	// software enable counts only in software mode
	task automatic t_soft();
		wr(wdt_pkg::ADDR_CFG, cfg(2, 2'h2));
		quiet(100);
		check(32'(lfosc_en_o), 32'h0);
		wr(wdt_pkg::ADDR_CTRL, 32'h1);
		rd(wdt_pkg::ADDR_CTRL, 32'h1, wdt_pkg::RESP_OKAY);
		check(32'(lfosc_en_o), 32'h1);
		gap(0, c);
		gap(0, c);
		check(32'(c >= (BASE << 2) && c <= (BASE << 2) + 1),
			32'h1);
		wr(wdt_pkg::ADDR_CFG, cfg(2, 2'h0)); // soft bit still set
		quiet(100);
		wr(wdt_pkg::ADDR_CTRL, 32'h0);
		$display("software enable test done");
	endtask

	// clear instruction, select change and clock failure, applied often, each hold off the timeout
	task automatic t_clear();
		wr(wdt_pkg::ADDR_CFG, cfg(4, 2'h3));
		for (int k = 0; k < 3; k++)
		begin
			wr(wdt_pkg::ADDR_CMD, 32'h1);
			c = rst_cnt;
			for (int i = 0; i < 6; i++)
			begin
				repeat (30) @(posedge clk_sys_i);
				if (k == 0)
					wr(wdt_pkg::ADDR_CMD, 32'h1);
				else if (k == 1)
					wr(wdt_pkg::ADDR_OSC, i[0] ? 32'h30 : 32'h40);
				else
					clk_fail_i <= 1'b1;
				@(posedge clk_sys_i);
				clk_fail_i <= 1'b0;
			end
			check(rst_cnt - c, 0);
			gap(0, c);
			// still counting a full period once left alone
			check(32'(c >= (BASE << 4) - 4 && c <= (BASE << 4) + 4),
				32'h1);
		end
		$display("clear test done");
	endtask

	// sleep stops the awake-only mode and wakes the always-on mode
	task automatic t_sleep();
		wr(wdt_pkg::ADDR_CFG, cfg(2, 2'h1));
		wr(wdt_pkg::ADDR_CMD, 32'h2);
		check(32'(sleeping_o), 32'h1);
		rd(wdt_pkg::ADDR_CMD, 32'h1, wdt_pkg::RESP_OKAY);
		quiet(100);
		wr(wdt_pkg::ADDR_CMD, 32'h4);
		gap(0, c);
		gap(0, c);
		check(32'(c >= (BASE << 2) && c <= (BASE << 2) + 1),
			32'h1);
		wr(wdt_pkg::ADDR_CFG, cfg(4, 2'h3));
		wr(wdt_pkg::ADDR_STAT, 32'h3);
		wr(wdt_pkg::ADDR_CMD, 32'h2);
		gap(1, c);
		check(32'(c >= (BASE << 4) - 4 && c <= (BASE << 4) + 6),
			32'h1);
		repeat (2) @(posedge clk_sys_i);
		check(32'(sleeping_o), 32'h0);
		rd(wdt_pkg::ADDR_STAT, 32'h2, wdt_pkg::RESP_OKAY);
		$display("sleep test done");
	endtask

	// main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		t_reset();
		t_period();
		t_irq();
		t_soft();
		t_clear();
		t_sleep();
		conclude();
	end

	// hang guard, well beyond the few thousand cycles the tests need
	initial
	begin
		#500000;
		err_count++;
		conclude();
	end
endmodule
